// file: design/mtirc_carrier.v
// Carrier generator: 7-bit counter alternating high and low phases
module mtirc_carrier (
  input  wire       clock,       // System clock
  input  wire       rst,         // Asynchronous reset, active high
  input  wire       tick,        // Carrier clock enable
  input  wire       run,         // Generator allowed to run
  input  wire [6:0] highPeriod,  // High phase reload value
  input  wire [6:0] lowPeriod,   // Low phase reload value
  output wire       carrierLvl   // Generated carrier level
);

  reg [6:0] phaseCnt_r;   // Carrier ticks spent in current phase
  reg       level_r;      // Current phase, 1 = high
  reg       started_r;    // First tick after start seen
  reg [6:0] phaseCnt_nxt;
  reg       level_nxt;
  reg       started_nxt;

  assign carrierLvl = level_r;

  // Next-state logic for the phase counter
  always @* begin
    phaseCnt_nxt = phaseCnt_r;
    level_nxt    = level_r;
    started_nxt  = started_r;
    if (!run) begin
      // Stopped: park low so the next start opens with a high phase
      phaseCnt_nxt = 7'h00;
      level_nxt    = 1'b0;
      started_nxt  = 1'b0;
    end else if (tick) begin
      if (!started_r) begin
        // Start with the high phase
        level_nxt    = 1'b1; // RQ22
        started_nxt  = 1'b1;
        phaseCnt_nxt = 7'h00;
      end else if (phaseCnt_r == (level_r ? highPeriod : lowPeriod)) begin
        // Value N lasts N+1 ticks, then the phase flips
        level_nxt    = ~level_r; // RQ18
        phaseCnt_nxt = 7'h00;
      end else begin
        phaseCnt_nxt = phaseCnt_r + 7'h01; // RQ10
      end
    end
  end

  // State registers
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phaseCnt_r <= 7'h00;
      level_r    <= 1'b0;
      started_r  <= 1'b0;
    end else begin
      phaseCnt_r <= phaseCnt_nxt;
      level_r    <= level_nxt;
      started_r  <= started_nxt;
    end
  end

endmodule // mtirc_carrier

// file: design/mtirc_timer.v
// Eight-bit modulo timer with match flag, driving the infrared carrier output gate
//
// Summary of operation
// RQ1: Counter equal to compare sets match flag
// RQ2: Count value read-only at 05h, resets zero
// RQ3: Compare register write-only at 06h, resets FFh
// RQ4: Software never programs compare value zero
// RQ5: Control: enable bit3, clear bit2, select bits1-0
// RQ6: Select 00/32, 01/64, 10/256, 11 carrier
// RQ7: Clear bit zeroes counter and flag, reads zero
// RQ8: Enable zero holds count, one advances
// RQ9: Software re-sets enable after stop release
// RQ10: Carrier uses 7-bit counter, two reload registers
// RQ11: Carrier clock fx or fx/2, build option
// RQ12: Both carrier period registers read and write
// RQ13: Low-period bit7 one forces steady high
// RQ14: Gate one passes carrier, zero drives low
// RQ15: Match copies buffered gate into gate
// RQ16: Gate drop during high waits carrier low
// RQ17: Gate zero stops carrier unless carrier-clocked
// RQ18: Period value N lasts N+1 ticks
// RQ19: Buffered gate-on waits out carrier high
// RQ20: After match counter wraps to zero next tick
// RQ21: Gate and gate buffer reset to zero
// RQ22: Carrier starts with high phase when enabled
`include "mtirc_regs.vh"

module mtirc_timer #(
  parameter CARRIER_DIV2 = 1  // 1: carrier clock fx/2, 0: carrier clock fx
) (
  input  wire       clock,        // System clock fx
  input  wire       rst,          // Asynchronous reset, active high
  input  wire [7:0] periphAddr,   // Peripheral register address
  input  wire       periphWrite,  // Peripheral write strobe
  input  wire       periphRead,   // Peripheral read strobe
  input  wire [7:0] dataBufIn,    // Data buffer contents to write
  output reg  [7:0] dataBufOut,   // Data buffer read result
  input  wire [6:0] rfAddr,       // Register file address
  input  wire       rfWrite,      // Register file write strobe
  input  wire       rfRead,       // Register file read strobe
  input  wire [3:0] rfWrData,     // Register file write nibble
  output reg  [3:0] rfRdData,     // Register file read nibble
  output wire       timerMatch,   // One-cycle pulse on compare match
  output wire       carrierOutPin // Carrier output pin level
);

  // Timer state
  reg [7:0] timerCountValue_r;    // Running count
  reg [7:0] timerCompareValue_r;  // Modulo value
  reg       countEnableBit_r;     // Count enable
  reg [1:0] countClockSel_r;      // Count clock select
  reg       timerMatchFlag_r;     // Sticky match flag
  reg [7:0] prescale_r;           // Free-running divider of fx
  reg       carrierDly_r;         // Carrier level one cycle ago, for edge

  // Carrier and gate state
  reg [7:0] carrierHighPeriod_r;  // High phase reload
  reg [7:0] carrierLowPeriod_r;   // Low phase reload, bit7 forces high
  reg       carrierGate_r;        // Gate currently applied
  reg       carrierGateBuffer_r;  // Gate value taken on next match
  reg       holdHigh_r;           // Keep pin high until carrier low
  reg       waitLow_r;            // Hide carrier until it next goes low
  reg       carrTick_r;           // Carrier clock enable divider
  reg       pin_r;                // Registered pin level

  wire       carrierLvl;          // Generator output
  wire       carrTick;            // Carrier clock enable
  wire       carrierRun;          // Generator allowed to run
  wire       countTick;           // Selected count clock enable
  wire       advance;             // Counter steps this cycle
  wire [7:0] countInc;            // Count plus one
  wire       matchNow;            // Counter reaches compare value
  wire       rfCtlWr;             // Control register written
  wire       clearReq;            // Counter clear requested
  wire       gateWr;              // Gate register written
  wire       flagWr;              // Flag register written
  wire       gateFromMatch;       // Match transfers the buffer
  wire       gateFallHigh;        // Gate drops while carrier high
  wire       gateRiseHigh;        // Buffered gate rises while carrier high
  wire       pinSource;           // Carrier or forced high

  // Control reset word, kept whole so its fields can be picked out by position
  localparam [3:0] CTL_RESET = `MTIRC_RST_CONTROL;

  assign carrierOutPin = pin_r;
  assign timerMatch    = matchNow;

  // Carrier clock is every fx edge, or every other one for fx/2
  assign carrTick = (CARRIER_DIV2 != 0) ? carrTick_r : 1'b1; // RQ11

  // Divider for the fx/2 carrier clock
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      carrTick_r <= 1'b0;
    end else begin
      carrTick_r <= ~carrTick_r;
    end
  end

  // Generator idles with the gate closed, except when it clocks the timer
  assign carrierRun = carrierGate_r ||
                      (countClockSel_r == `MTIRC_SEL_CARRIER); // RQ17

  mtirc_carrier uCarrier (
    .clock      (clock),
    .rst        (rst),
    .tick       (carrTick),
    .run        (carrierRun),
    .highPeriod (carrierHighPeriod_r[6:0]),
    .lowPeriod  (carrierLowPeriod_r[6:0]),
    .carrierLvl (carrierLvl)
  );

  // Prescaler and carrier edge history
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_r   <= 8'h00;
      carrierDly_r <= 1'b0;
    end else begin
      prescale_r   <= prescale_r + 8'h01;
      carrierDly_r <= carrierLvl;
    end
  end

  // Count clock select; the carrier clocks the timer on its rising edge
  assign countTick =
    (countClockSel_r == `MTIRC_SEL_DIV32)   ? ((prescale_r & `MTIRC_DIV32_MASK) == 8'h00) :
    (countClockSel_r == `MTIRC_SEL_DIV64)   ? ((prescale_r & `MTIRC_DIV64_MASK) == 8'h00) :
    (countClockSel_r == `MTIRC_SEL_CARRIER) ? (carrierLvl & ~carrierDly_r) :
    ((prescale_r & `MTIRC_DIV256_MASK) == 8'h00); // RQ6

  // Count only while enabled
  assign advance  = countTick & countEnableBit_r; // RQ8
  assign countInc = timerCountValue_r + 8'h01;
  // Match when the next count equals compare; zero compare matches at most once, on the step from FFh, then the count parks at zero
  assign matchNow = advance && (timerCountValue_r != timerCompareValue_r) &&
                    (countInc == timerCompareValue_r); // RQ1

  // Register file strobes
  assign rfCtlWr  = rfWrite && (rfAddr == `MTIRC_RF_CONTROL);
  assign clearReq = rfCtlWr && rfWrData[`MTIRC_CTL_CLR];
  assign gateWr   = rfWrite && (rfAddr == `MTIRC_RF_GATE);
  assign flagWr   = rfWrite && (rfAddr == `MTIRC_RF_FLAG);

  // Counter: clear has priority, match value wraps to zero next tick
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timerCountValue_r <= `MTIRC_RST_COUNT; // RQ2
    end else if (clearReq) begin
      timerCountValue_r <= `MTIRC_RST_COUNT; // RQ7
    end else if (advance) begin
      if (timerCountValue_r == timerCompareValue_r) begin
        timerCountValue_r <= 8'h00; // RQ20
      end else begin
        timerCountValue_r <= countInc;
      end
    end
  end

  // Match flag: a match in the same cycle as a clear or a write wins
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timerMatchFlag_r <= 1'b0;
    end else if (matchNow) begin
      timerMatchFlag_r <= 1'b1; // RQ1
    end else if (clearReq) begin
      timerMatchFlag_r <= 1'b0; // RQ7
    end else if (flagWr) begin
      // Software may raise or cancel a pending request
      timerMatchFlag_r <= rfWrData[`MTIRC_FLAG_MATCH];
    end
  end

  // Timer control; the clear bit is an action, never stored
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      countEnableBit_r <= CTL_RESET[`MTIRC_CTL_EN];
      countClockSel_r  <= CTL_RESET[`MTIRC_CTL_SEL_HI:`MTIRC_CTL_SEL_LO];
    end else if (rfCtlWr) begin
      countEnableBit_r <= rfWrData[`MTIRC_CTL_EN]; // RQ5
      countClockSel_r  <= rfWrData[`MTIRC_CTL_SEL_HI:`MTIRC_CTL_SEL_LO]; // RQ5
    end
  end

  // Peripheral writes; the counter address is not writable
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      timerCompareValue_r <= `MTIRC_RST_COMPARE; // RQ3
      carrierHighPeriod_r <= `MTIRC_RST_CARR;
      carrierLowPeriod_r  <= `MTIRC_RST_CARR;
    end else if (periphWrite) begin
      case (periphAddr)
        `MTIRC_PA_COMPARE: begin
          timerCompareValue_r <= dataBufIn; // RQ3
        end
        `MTIRC_PA_CARR_HIGH: begin
          carrierHighPeriod_r <= dataBufIn; // RQ12
        end
        `MTIRC_PA_CARR_LOW: begin
          carrierLowPeriod_r  <= dataBufIn; // RQ12
        end
        default: begin
          // Count value and unused addresses ignore writes
          timerCompareValue_r <= timerCompareValue_r; // RQ2
        end
      endcase
    end
  end

  // Peripheral read; write-only and unused addresses return zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dataBufOut <= 8'h00;
    end else if (periphRead) begin
      case (periphAddr)
        `MTIRC_PA_COUNT:     dataBufOut <= timerCountValue_r; // RQ2
        `MTIRC_PA_CARR_HIGH: dataBufOut <= carrierHighPeriod_r; // RQ12
        `MTIRC_PA_CARR_LOW:  dataBufOut <= carrierLowPeriod_r; // RQ12
        default:             dataBufOut <= 8'h00; // RQ3
      endcase
    end
  end

  // Register file read; the clear bit reads zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rfRdData <= 4'h0;
    end else if (rfRead) begin
      case (rfAddr)
        `MTIRC_RF_CONTROL: begin
          rfRdData <= {countEnableBit_r, 1'b0, countClockSel_r}; // RQ7
        end
        `MTIRC_RF_GATE: begin
          rfRdData <= {2'b00, carrierGateBuffer_r, carrierGate_r};
        end
        `MTIRC_RF_FLAG: begin
          rfRdData <= {3'b000, timerMatchFlag_r};
        end
        default: begin
          rfRdData <= 4'h0;
        end
      endcase
    end
  end

  // The buffered gate moves into the gate on every match
  assign gateFromMatch = matchNow; // RQ15
  // Gate about to close while the carrier is in a high pulse
  assign gateFallHigh = carrierGate_r && carrierLvl &&
                        ((gateFromMatch && !carrierGateBuffer_r) ||
                         (!gateFromMatch && gateWr && !rfWrData[`MTIRC_GATE_NOW]));
  // Gate opened by transfer while the carrier is mid-high
  assign gateRiseHigh = !carrierGate_r && gateFromMatch &&
                        carrierGateBuffer_r && carrierLvl;

  // Gate and its buffer; a match transfer beats a direct gate write
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      carrierGate_r       <= 1'b0; // RQ21
      carrierGateBuffer_r <= 1'b0; // RQ21
    end else begin
      if (gateWr) begin
        carrierGateBuffer_r <= rfWrData[`MTIRC_GATE_BUF];
      end
      if (gateFromMatch) begin
        carrierGate_r <= carrierGateBuffer_r; // RQ15
      end else if (gateWr) begin
        carrierGate_r <= rfWrData[`MTIRC_GATE_NOW];
      end
    end
  end

  // Pulse-width guards: both end when the carrier goes low
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      holdHigh_r <= 1'b0;
      waitLow_r  <= 1'b0;
    end else begin
      if (gateFallHigh) begin
        holdHigh_r <= 1'b1; // RQ16
      end else if (!carrierLvl) begin
        holdHigh_r <= 1'b0; // RQ16
      end
      if (gateRiseHigh) begin
        // A partial pulse is not shown; the first full one follows a low phase
        waitLow_r <= 1'b1; // RQ19
      end else if (!carrierLvl) begin
        waitLow_r <= 1'b0; // RQ19
      end
    end
  end

  // Bit7 of the low register swaps the carrier for a steady high
  assign pinSource = carrierLowPeriod_r[`MTIRC_LOW_FORCE] ? 1'b1 :
                     (carrierLvl & ~waitLow_r); // RQ13

  // Pin register: gate passes the source, closed gate drives low once any held high pulse ends
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0; // RQ21
    end else begin
      pin_r <= (carrierGate_r & pinSource) |
               (holdHigh_r & carrierLvl); // RQ14
    end
  end

endmodule // mtirc_timer

// file: pkg/mtirc_regs.vh
// Offsets, field positions, reset values and clock ratios of the modulo timer and carrier
`ifndef MTIRC_REGS_VH
`define MTIRC_REGS_VH

// Peripheral register addresses (data buffer transfers)
`define MTIRC_PA_COUNT     8'h05
`define MTIRC_PA_COMPARE   8'h06
`define MTIRC_PA_CARR_HIGH 8'h08
`define MTIRC_PA_CARR_LOW  8'h09

// Register file addresses (nibble wide)
`define MTIRC_RF_CONTROL   7'h33
`define MTIRC_RF_GATE      7'h35
`define MTIRC_RF_FLAG      7'h3f

// Timer control fields
`define MTIRC_CTL_EN       3
`define MTIRC_CTL_CLR      2
`define MTIRC_CTL_SEL_HI   1
`define MTIRC_CTL_SEL_LO   0

// Gate register fields
`define MTIRC_GATE_NOW     0
`define MTIRC_GATE_BUF     1

// Match flag field
`define MTIRC_FLAG_MATCH   0

// Bit of the low-period register that forces a steady high pin
`define MTIRC_LOW_FORCE    7

// Reset values
`define MTIRC_RST_COUNT    8'h00
`define MTIRC_RST_COMPARE  8'hff
`define MTIRC_RST_CONTROL  4'h8
`define MTIRC_RST_CARR     8'h00

// Count clock select codes
`define MTIRC_SEL_DIV32    2'b00
`define MTIRC_SEL_DIV64    2'b01
`define MTIRC_SEL_CARRIER  2'b11

// Prescaler tap masks: divide by 32, 64 and 256
`define MTIRC_DIV32_MASK   8'h1f
`define MTIRC_DIV64_MASK   8'h3f
`define MTIRC_DIV256_MASK  8'hff

`endif

// file: testbench/mtirc_led_model.sv
// Infrared LED load on the carrier pin, measuring lit and dark run lengths
module mtirc_led_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic carrierOutPin,
  output int        highLen,
  output int        lowLen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ledOn_r;  // Pin level seen at the previous edge
  int   run_r;    // Edges the present level has lasted
  // A level change closes the run; widths are whole clocks
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ledOn_r <= 1'b0;
      run_r <= 0;
      highLen <= 0;
      lowLen <= 0;
    end else if (carrierOutPin !== ledOn_r) begin
      if (ledOn_r) begin
        highLen <= run_r;
      end else begin
        lowLen <= run_r;
      end
      ledOn_r <= carrierOutPin;
      run_r <= 1;
    end else begin
      run_r <= run_r + 1;
    end
  end
endmodule // mtirc_led_model

// file: testbench/mtirc_timer_assertions.sv
// Port-level checker for the modulo timer and carrier generator
module mtirc_timer_assertions (
  input wire       clock,
  input wire       rst,
  input wire [7:0] periphAddr,
  input wire       periphWrite,
  input wire       periphRead,
  input wire [7:0] dataBufIn,
  input wire [7:0] dataBufOut,
  input wire [6:0] rfAddr,
  input wire       rfWrite,
  input wire       rfRead,
  input wire [3:0] rfWrData,
  input wire [3:0] rfRdData,
  input wire       timerMatch,
  input wire       carrierOutPin
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic countEn_r;  // Shadow of the count enable bit
  // Follow enable writes so hold checks only arm while counting is off
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      countEn_r <= 1'b1;
    end else if (rfWrite && rfAddr == 7'h33) begin
      countEn_r <= rfWrData[3];
    end
  end
  cmp_wo_read_a:
    assert property (periphRead && periphAddr == 8'h06 |=> dataBufOut == 8'h00)
    else $error("compare register read back non-zero");
  clr_reads_zero_a:
    assert property (rfRead && rfAddr == 7'h33 |=> !rfRdData[2])
    else $error("clear bit read back as one");
  match_pulse_a:
    assert property (timerMatch |=> !timerMatch)
    else $error("match pulse longer than one cycle");
  flag_set_a:
    assert property (timerMatch ##1 (rfRead && rfAddr == 7'h3f) |=> rfRdData[0])
    else $error("match flag not set after match");
  clear_count_a:
    assert property (rfWrite && rfAddr == 7'h33 && rfWrData[2] && !rfWrData[3]
      ##2 (periphRead && periphAddr == 8'h05) |=> dataBufOut == 8'h00)
    else $error("count not zero after clear");
  hold_count_a:
    assert property ((periphRead && periphAddr == 8'h05 && !countEn_r) ##1 !rfWrite
      ##1 (periphRead && periphAddr == 8'h05 && !rfWrite) |=> $stable(dataBufOut))
    else $error("count moved while disabled");
  period_echo_a:
    assert property ((periphWrite && periphAddr == 8'h08) ##2
      (periphRead && periphAddr == 8'h08 && !periphWrite) |=> dataBufOut == $past(dataBufIn, 3))
    else $error("high period register did not read back");
  buf_out_hold_a:
    assert property (!periphRead |=> $stable(dataBufOut))
    else $error("data buffer changed without a read");
  cover property (timerMatch);
  cover property ($rose(carrierOutPin));
  cover property (timerMatch ##1 (rfRead && rfAddr == 7'h3f));
endmodule // mtirc_timer_assertions

bind mtirc_timer mtirc_timer_assertions mtirc_timer_assertions_i (
  .clock(clock), .rst(rst), .periphAddr(periphAddr), .periphWrite(periphWrite),
  .periphRead(periphRead), .dataBufIn(dataBufIn), .dataBufOut(dataBufOut),
  .rfAddr(rfAddr), .rfWrite(rfWrite), .rfRead(rfRead), .rfWrData(rfWrData),
  .rfRdData(rfRdData), .timerMatch(timerMatch), .carrierOutPin(carrierOutPin));

// file: testbench/tb_mtirc_timer.sv
// Self-checking bench for the modulo timer and carrier generator
module tb_mtirc_timer;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit rf; bit wr; logic [7:0] a; logic [7:0] d;} mtirc_row_t;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] periphAddr = 8'h00;
  logic       periphWrite = 1'b0;
  logic       periphRead = 1'b0;
  logic [7:0] dataBufIn = 8'h00;
  wire  [7:0] dataBufOut;
  logic [6:0] rfAddr = 7'h00;
  logic       rfWrite = 1'b0;
  logic       rfRead = 1'b0;
  logic [3:0] rfWrData = 4'h0;
  wire  [3:0] rfRdData;
  wire        timerMatch;
  wire        carrierOutPin;
  int         highLen, lowLen, t0;
  int         cyc = 0;
  int         error_cnt = 0;
  int         n_checks = 0;
  logic [7:0] v;
  // Match spacing per select code with compare 3; carrier is 2*(1+1)+2*(2+1) clocks
  int         per [4] = '{128, 256, 1024, 40};
  // Register traffic: read rows hold the expected value in d
  mtirc_row_t rows [14] = '{'{1, 0, 8'h33, 8'h08}, '{1, 1, 8'h33, 8'h04},
    '{0, 0, 8'h05, 8'h00}, '{0, 0, 8'h05, 8'h00}, '{0, 1, 8'h05, 8'h5a},
    '{0, 0, 8'h05, 8'h00}, '{1, 0, 8'h33, 8'h00}, '{0, 0, 8'h06, 8'h00},
    '{0, 1, 8'h08, 8'h01}, '{0, 0, 8'h08, 8'h01}, '{0, 1, 8'h09, 8'h02},
    '{0, 0, 8'h09, 8'h02}, '{1, 0, 8'h35, 8'h00}, '{1, 0, 8'h3f, 8'h00}};

  mtirc_timer #(.CARRIER_DIV2(1)) mtirc_timer_i (.clock(clock), .rst(rst),
    .periphAddr(periphAddr), .periphWrite(periphWrite), .periphRead(periphRead),
    .dataBufIn(dataBufIn), .dataBufOut(dataBufOut), .rfAddr(rfAddr), .rfWrite(rfWrite),
    .rfRead(rfRead), .rfWrData(rfWrData), .rfRdData(rfRdData), .timerMatch(timerMatch),
    .carrierOutPin(carrierOutPin));
  mtirc_led_model mtirc_led_model_i (.clock(clock), .rst(rst),
    .carrierOutPin(carrierOutPin), .highLen(highLen), .lowLen(lowLen));

  always #4 clock = ~clock;
  // Cycle count doubles as the hang guard
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One strobe cycle on either register path; reads are taken after the answer edge
  task automatic acc(input bit rf, input bit wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clock);
    rfAddr = a[6:0];
    rfWrData = d[3:0];
    periphAddr = a;
    dataBufIn = d;
    {rfWrite, rfRead} = rf ? {wr, !wr} : 2'b00;
    {periphWrite, periphRead} = rf ? 2'b00 : {wr, !wr};
    @(negedge clock);
    {rfWrite, rfRead, periphWrite, periphRead} = 4'h0;
    q = rf ? {4'h0, rfRdData} : dataBufOut;
  endtask

  // Returns at the falling edge where the match pulse is seen
  task automatic waitMatch();
    int k;
    k = 0;
    @(negedge clock);
    while (timerMatch !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    if (k == 3000) chk("match wait", 16'h0, 16'h1);
  endtask

  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    foreach (rows[i]) begin
      acc(rows[i].rf, rows[i].wr, rows[i].a, rows[i].d, v);
      if (!rows[i].wr) chk($sformatf("row %0d", i), v, rows[i].d);
    end
    // Compare value three, never zero
    acc(0, 1, 8'h06, 8'h03, v);
    // Every select code, clear and enable together; code 3 runs the carrier ungated
    for (int s = 0; s < 4; s++) begin
      acc(1, 1, 8'h33, 8'h0c + 8'(s), v);
      waitMatch();
      t0 = cyc;
      waitMatch();
      chk($sformatf("period sel %0d", s), 16'(cyc - t0), 16'(per[s]));
    end
    waitMatch();
    acc(1, 0, 8'h3f, 8'h00, v);
    chk("match flag", v, 8'h01);
    acc(1, 1, 8'h33, 8'h0f, v);
    acc(1, 0, 8'h3f, 8'h00, v);
    chk("flag cleared", v, 8'h00);
    // Buffered gate on: pin waits for the next match
    acc(1, 1, 8'h35, 8'h02, v);
    chk("pin gated off", 16'(carrierOutPin), 16'h0);
    waitMatch();
    repeat (40) @(negedge clock);
    chk("high width", 16'(highLen), 16'd4);
    chk("low width", 16'(lowLen), 16'd6);
    acc(1, 0, 8'h35, 8'h00, v);
    chk("gate copied", v, 8'h03);
    // Buffered gate off takes effect at the next match
    acc(1, 1, 8'h35, 8'h01, v);
    waitMatch();
    repeat (12) @(negedge clock);
    for (int k = 0; k < 8; k++) begin
      chk("pin low", 16'(carrierOutPin), 16'h0);
      @(negedge clock);
    end
    // Force bit gives a steady high level while gated
    acc(0, 1, 8'h09, 8'h82, v);
    acc(1, 1, 8'h35, 8'h03, v);
    repeat (4) @(negedge clock);
    for (int k = 0; k < 8; k++) begin
      chk("pin forced", 16'(carrierOutPin), 16'h1);
      @(negedge clock);
    end
    // Disabled timer keeps its cleared count; two or three taps, so a leak cannot wrap
    acc(1, 1, 8'h33, 8'h05, v);
    repeat (150) @(negedge clock);
    acc(0, 0, 8'h05, 8'h00, v);
    chk("held count", v, 8'h00);
    // Reset in mid-run drops the forced-high pin and restores control, gate and low period
    @(negedge clock);
    rst = 1'b1;
    repeat (3) @(negedge clock);
    chk("pin in reset", 16'(carrierOutPin), 16'h0);
    rst = 1'b0;
    acc(1, 0, 8'h33, 8'h00, v);
    chk("control reset", v, 8'h08);
    acc(1, 0, 8'h35, 8'h00, v);
    chk("gate reset", v, 8'h00);
    acc(0, 0, 8'h09, 8'h00, v);
    chk("low period reset", v, 8'h00);
    finish_test();
  end
endmodule // tb_mtirc_timer
